// ===== hw/asom_consts.vh
`ifndef ASOM_CONSTS_VH
`define ASOM_CONSTS_VH

// Register byte addresses
`define ASOM_ADDR_CTRL 8'h00
`define ASOM_ADDR_LINE 8'h04
`define ASOM_ADDR_EXPO 8'h08
`define ASOM_ADDR_DBNC 8'h0c
`define ASOM_ADDR_STDL 8'h10
`define ASOM_ADDR_TXDL 8'h14
`define ASOM_ADDR_GEOM 8'h18
`define ASOM_ADDR_ROUT 8'h1c
`define ASOM_ADDR_STAT 8'h20

// Control fields
`define ASOM_CTRL_ARM 0
`define ASOM_CTRL_DBEN 1

// Line fields
`define ASOM_LINE_DIR 0
`define ASOM_LINE_SRC1 4
`define ASOM_LINE_SRCS 8

// Line source codes
`define ASOM_SRC_LOW 2'h0
`define ASOM_SRC_EXPO 2'h1
`define ASOM_SRC_FRAME 2'h2

// Geometry fields
`define ASOM_GEOM_H_LSB 0
`define ASOM_GEOM_TAP_LSB 16
`define ASOM_GEOM_PCLK 20

// Reset values: times in microseconds, height in lines
`define ASOM_RST_EXPO 24'h00_0064
`define ASOM_RST_STDL 16'h0011
`define ASOM_RST_TXDL 16'h0005
`define ASOM_RST_HEIGHT 16'h0400

// Time base: 1 us at 200 MHz
`define ASOM_TB_NS 1000
`define ASOM_CLK_NS 5
`define ASOM_TB_CYC (`ASOM_TB_NS / `ASOM_CLK_NS)

`endif

// ===== hw/asom_ticker.v
`default_nettype none

// ----------------------------------------
// One-microsecond time base pulse
// ----------------------------------------
module asom_ticker (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Pulse
    output reg tick_o
);
    `include "asom_consts.vh"

    localparam integer TICK_CYC = `ASOM_TB_CYC;
    localparam [7:0] TICK_LAST = TICK_CYC[7:0] - 8'h01;
    reg [7:0] cnt_q;

    always @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= 8'h00;
            tick_o <= 1'b0;
        end else begin
            tick_o <= (cnt_q == TICK_LAST);
            if (cnt_q == TICK_LAST) begin
                cnt_q <= 8'h00;
            end else begin
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end
endmodule // asom_ticker

`default_nettype wire

// ===== hw/asom_top.v
// What this block does
// R1: Exposure status selectable on either output line
// R2: Frame cycle status selectable on either line
// R3: Line 1 driven only when set output
// R4: Frame cycle rises entering trigger wait
// R5: Frame cycle falls at next exposure end
// R6: Exposure starts fixed delay after trigger rise
// R7: Debounce time adds to start delay
// R8: Readout starts when exposure completes
// R9: Transmission starts delay after readout start
// R10: Transmission lasts exactly the readout time
// R11: Readout time readable in microseconds
// R12: Readout time recomputed on geometry changes
// R13: Exposure status high during exposure only
// R14: Output mux registered, glitch free
//
// Implementation choices: the placing of the registers and the Wishbone slave port.
`default_nettype none

module asom_top (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Trigger input
    input wire external_frame_start_trigger_i,
    // General-purpose line 1
    input wire line1_i,
    output reg line1_o,
    output reg line1_oe_o,
    // Spare interface output
    output reg interface_spare_output_o,
    // Status
    output reg exposure_in_progress_o,
    output reg frame_period_status_o,
    output reg readout_active_o,
    output reg transmit_active_o
);
    `include "asom_consts.vh"

    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_WAIT = 3'd1;
    localparam [2:0] ST_DELAY = 3'd2;
    localparam [2:0] ST_EXPO = 3'd3;
    localparam [2:0] ST_READ = 3'd4;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg [1:0] ctrl_q;
    reg [9:0] line_q;
    reg [23:0] expo_q;
    reg [15:0] dbnc_q;
    reg [15:0] stdl_q;
    reg [15:0] txdl_q;
    reg [20:0] geom_q;
    reg [23:0] rout_q;
    reg [20:0] geom_seen_q;
    reg [2:0] st_q;
    reg [23:0] cnt_q;
    reg [23:0] rcnt_q;
    reg [15:0] tdly_q;
    reg tx_pend_q;
    reg [23:0] tcnt_q;
    reg trig_q;
    wire tick;
    wire trig_rise;
    wire hit;
    wire wr_go;
    reg [31:0] rdata;
    wire [31:0] wmerged;

    asom_ticker u_tick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_o(tick)
    );

    // Per-lane write merge
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] sel;
        integer i;
        begin
            for (i = 0; i < 4; i = i + 1) begin
                merge[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
            end
        end
    endfunction

    // Line mux decode
    function pick;
        input [1:0] src;
        input expo;
        input frm;
        begin
            case (src)
                `ASOM_SRC_EXPO: pick = expo;
                `ASOM_SRC_FRAME: pick = frm;
                default: pick = 1'b0;
            endcase
        end
    endfunction

    // ----------------------------------------
    // Wishbone slave
    // ----------------------------------------
    assign hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // Write commits at the ack edge, while the master still holds it
    assign wr_go = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
    assign wmerged = merge(rdata, wb_dat_i, wb_sel_i);

    always @* begin
        case (wb_adr_i)
            `ASOM_ADDR_CTRL: rdata = {30'h0000_0000, ctrl_q};
            `ASOM_ADDR_LINE: rdata = {22'h00_0000, line_q};
            `ASOM_ADDR_EXPO: rdata = {8'h00, expo_q};
            `ASOM_ADDR_DBNC: rdata = {16'h0000, dbnc_q};
            `ASOM_ADDR_STDL: rdata = {16'h0000, stdl_q};
            `ASOM_ADDR_TXDL: rdata = {16'h0000, txdl_q};
            `ASOM_ADDR_GEOM: rdata = {11'h000, geom_q};
            `ASOM_ADDR_ROUT: rdata = {8'h00, rout_q}; // R11
            `ASOM_ADDR_STAT: rdata = {26'h000_0000, line1_i, st_q, readout_active_o, transmit_active_o};
            default: rdata = 32'h0000_0000;
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            ctrl_q <= 2'h0;
            line_q <= 10'h000;
            expo_q <= `ASOM_RST_EXPO;
            dbnc_q <= 16'h0000;
            stdl_q <= `ASOM_RST_STDL;
            txdl_q <= `ASOM_RST_TXDL;
            geom_q <= {1'b0, 4'h1, `ASOM_RST_HEIGHT};
        end else begin
            wb_ack_o <= hit;
            wb_dat_o <= hit ? rdata : 32'h0000_0000;
            if (wr_go) begin
                case (wb_adr_i)
                    `ASOM_ADDR_CTRL: ctrl_q <= wmerged[1:0];
                    `ASOM_ADDR_LINE: line_q <= wmerged[9:0] & 10'h331; // R1 R2
                    `ASOM_ADDR_EXPO: expo_q <= wmerged[23:0];
                    `ASOM_ADDR_DBNC: dbnc_q <= wmerged[15:0];
                    `ASOM_ADDR_STDL: stdl_q <= wmerged[15:0];
                    `ASOM_ADDR_TXDL: txdl_q <= wmerged[15:0];
                    `ASOM_ADDR_GEOM: geom_q <= wmerged[20:0];
                    default: ;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Readout time
    // ----------------------------------------
    // Per-line cost: 16 us / taps, halved at fast pixel clock
    wire [3:0] taps = (geom_q[19:16] == 4'h0) ? 4'h1 : geom_q[19:16];
    wire [4:0] per_line = 5'd16 / {1'b0, taps} >> geom_q[`ASOM_GEOM_PCLK];
    wire [4:0] per_line_nz = (per_line == 5'd0) ? 5'd1 : per_line;

    always @(posedge clk_i) begin
        if (rst_i) begin
            rout_q <= 24'h00_0000;
            geom_seen_q <= 21'h00_0000;
        end else if (geom_q != geom_seen_q || rout_q == 24'h00_0000) begin
            geom_seen_q <= geom_q;
            rout_q <= geom_q[15:0] * {19'h0, per_line_nz}; // R12
        end
    end

    // ----------------------------------------
    // Acquisition sequencer
    // ----------------------------------------
    assign trig_rise = external_frame_start_trigger_i & ~trig_q;

    always @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= ST_IDLE;
            cnt_q <= 24'h00_0000;
            rcnt_q <= 24'h00_0000;
            trig_q <= 1'b0;
            exposure_in_progress_o <= 1'b0;
            frame_period_status_o <= 1'b0;
            readout_active_o <= 1'b0;
        end else begin
            trig_q <= external_frame_start_trigger_i;
            case (st_q)
                ST_IDLE: begin
                    if (ctrl_q[`ASOM_CTRL_ARM]) begin
                        st_q <= ST_WAIT;
                        frame_period_status_o <= 1'b1; // R4
                    end
                end
                ST_WAIT: begin
                    if (!ctrl_q[`ASOM_CTRL_ARM]) begin
                        st_q <= ST_IDLE;
                        frame_period_status_o <= 1'b0;
                    end else if (trig_rise) begin
                        st_q <= ST_DELAY;
                        cnt_q <= {8'h00, stdl_q} + (ctrl_q[`ASOM_CTRL_DBEN] ? {8'h00, dbnc_q} : 24'h0); // R6 R7
                    end
                end
                ST_DELAY: begin
                    if (tick) begin
                        if (cnt_q <= 24'h00_0001) begin
                            st_q <= ST_EXPO;
                            exposure_in_progress_o <= 1'b1; // R13
                            cnt_q <= expo_q;
                        end else begin
                            cnt_q <= cnt_q - 24'h00_0001;
                        end
                    end
                end
                ST_EXPO: begin
                    if (tick) begin
                        if (cnt_q <= 24'h00_0001) begin
                            exposure_in_progress_o <= 1'b0; // R13
                            frame_period_status_o <= 1'b0; // R5
                            readout_active_o <= 1'b1; // R8
                            rcnt_q <= rout_q;
                            st_q <= ST_READ;
                        end else begin
                            cnt_q <= cnt_q - 24'h00_0001;
                        end
                    end
                end
                ST_READ: begin
                    if (tick) begin
                        if (rcnt_q <= 24'h00_0001) begin
                            readout_active_o <= 1'b0;
                            st_q <= ST_IDLE;
                        end else begin
                            rcnt_q <= rcnt_q - 24'h00_0001;
                        end
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Transmission timing
    // ----------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            tx_pend_q <= 1'b0;
            tdly_q <= 16'h0000;
            tcnt_q <= 24'h00_0000;
            transmit_active_o <= 1'b0;
        end else if (st_q == ST_EXPO && tick && cnt_q <= 24'h00_0001) begin
            tx_pend_q <= 1'b1;
            tdly_q <= txdl_q; // R9
            tcnt_q <= rout_q; // R10
        end else if (tx_pend_q && tick) begin
            if (tdly_q <= 16'h0001) begin
                tx_pend_q <= 1'b0;
                transmit_active_o <= 1'b1;
            end else begin
                tdly_q <= tdly_q - 16'h0001;
            end
        end else if (transmit_active_o && tick) begin
            if (tcnt_q <= 24'h00_0001) begin
                transmit_active_o <= 1'b0;
            end else begin
                tcnt_q <= tcnt_q - 24'h00_0001;
            end
        end
    end

    // ----------------------------------------
    // Output line mux
    // ----------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            line1_o <= 1'b0;
            line1_oe_o <= 1'b0;
            interface_spare_output_o <= 1'b0;
        end else begin
            line1_oe_o <= line_q[`ASOM_LINE_DIR]; // R3
            line1_o <= line_q[`ASOM_LINE_DIR] &
                pick(line_q[5:4], exposure_in_progress_o, frame_period_status_o); // R3 R14
            interface_spare_output_o <= pick(line_q[9:8], exposure_in_progress_o, frame_period_status_o); // R1 R2 R14
        end
    end
endmodule // asom_top

`default_nettype wire

// ===== verif/asom_props.sv
`default_nettype none
// ----
// Port checks
// ----
module asom_props (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Watched ports
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic line1_o,
    input wire logic interface_spare_output_o,
    input wire logic exposure_in_progress_o,
    input wire logic frame_period_status_o,
    input wire logic readout_active_o,
    input wire logic transmit_active_o
);
    default clocking dc @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    a_frame_covers_expo: assert property (exposure_in_progress_o |-> frame_period_status_o)
        else $error("frame low in exposure");
    a_frame_ends_expo: assert property ($fell(exposure_in_progress_o) |-> !frame_period_status_o)
        else $error("frame not ended");
    a_readout_follows: assert property ($fell(exposure_in_progress_o) |-> readout_active_o)
        else $error("readout not started");
    a_tx_start_gap: assert property ($rose(readout_active_o) |-> !transmit_active_o [*8])
        else $error("transmit too early");
    a_expo_min_len: assert property ($rose(exposure_in_progress_o) |-> exposure_in_progress_o [*8])
        else $error("exposure too short");
    a_spare_src_ok: assert property (interface_spare_output_o |->
        $past(exposure_in_progress_o) || $past(frame_period_status_o))
        else $error("spare without source");
    a_line_src_ok: assert property (line1_o |->
        $past(exposure_in_progress_o) || $past(frame_period_status_o))
        else $error("line without source");
    cover property ($rose(transmit_active_o));
    cover property ($fell(exposure_in_progress_o));
    cover property (line1_o && interface_spare_output_o);
endmodule // asom_props

bind asom_top asom_props chk_u (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .line1_o, .interface_spare_output_o,
    .exposure_in_progress_o, .frame_period_status_o, .readout_active_o, .transmit_active_o
);
`default_nettype wire

// ===== verif/asom_far_end.sv
`default_nettype none
// ----
// Trigger source and line load
// ----
module asom_far_end (
    // Clock and bench request
    input wire logic clk_i,
    input wire logic fire_i,
    // Device pins
    input wire logic line1_o,
    input wire logic line1_oe_o,
    output var logic trig_o,
    output wire logic line_o
);
    always @(posedge clk_i) begin
        trig_o <= fire_i;
    end
    // Pull-down when undriven
    assign line_o = line1_oe_o ? line1_o : 1'b0;
endmodule // asom_far_end
`default_nettype wire

// ===== verif/asom_tb_top.sv
`default_nettype none
`include "asom_consts.vh"
module asom_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TK = 200;
    typedef struct {logic wr; logic [7:0] wa; logic [31:0] wd; logic [7:0] ra; logic [31:0] ex;} asom_row_t;
    asom_row_t rows [9] = '{
        '{1'b0, 8'h00, 32'h0000_0000, `ASOM_ADDR_EXPO, 32'h0000_0064},
        '{1'b0, 8'h00, 32'h0000_0000, `ASOM_ADDR_STDL, 32'h0000_0011},
        '{1'b0, 8'h00, 32'h0000_0000, `ASOM_ADDR_TXDL, 32'h0000_0005},
        '{1'b0, 8'h00, 32'h0000_0000, `ASOM_ADDR_GEOM, 32'h0001_0400},
        '{1'b0, 8'h00, 32'h0000_0000, `ASOM_ADDR_ROUT, 32'h0000_4000},
        '{1'b1, `ASOM_ADDR_GEOM, 32'h0018_0003, `ASOM_ADDR_ROUT, 32'h0000_0003},
        '{1'b1, `ASOM_ADDR_GEOM, 32'h0008_0003, `ASOM_ADDR_ROUT, 32'h0000_0006},
        '{1'b1, `ASOM_ADDR_LINE, 32'hffff_ffff, `ASOM_ADDR_LINE, 32'h0000_0331},
        '{1'b1, 8'h24, 32'hffff_ffff, 8'h24, 32'h0000_0000}};
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, fire = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [31:0] wb_dat = 32'h0000_0000, rd, q;
    logic ack, trig, line_w, l1o, l1oe, spare, expo, frm, ro, tx;
    int fail_count = 0, compares = 0, k, n, d, r, t;
    asom_top dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat), .wb_dat_o(rd), .wb_ack_o(ack),
        .external_frame_start_trigger_i(trig), .line1_i(line_w), .line1_o(l1o), .line1_oe_o(l1oe),
        .interface_spare_output_o(spare), .exposure_in_progress_o(expo), .frame_period_status_o(frm),
        .readout_active_o(ro), .transmit_active_o(tx));
    asom_far_end far_u (.clk_i(clk_i), .fire_i(fire), .line1_o(l1o), .line1_oe_o(l1oe),
        .trig_o(trig), .line_o(line_w));
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] dw, output logic [31:0] dr);
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_dat <= dw;
        do @(posedge clk_i); while (ack !== 1'b1);
        dr = rd;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask
    task automatic chk_val(input string nm, input logic [31:0] ex, input logic [31:0] got);
        compares++;
        if (got !== ex) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic chk_bit(input string nm, input logic ex, input logic got);
        compares++;
        if (got !== ex) begin
            fail_count++;
            $display("MISMATCH %s expected %b seen %b", nm, ex, got);
        end
    endtask
    // Length in ticks, one tick of phase slack
    task automatic chk_len(input string nm, input int ticks, input int got);
        compares++;
        if (got < (ticks - 1) * TK || got > (ticks + 1) * TK) begin
            fail_count++;
            $display("MISMATCH %s expected %0d seen %0d", nm, ticks * TK, got);
        end
    endtask
    task automatic wait_for(ref logic s, input logic v, output int c);
        c = 0;
        while (s !== v && c < 5000) begin
            @(posedge clk_i);
            c++;
        end
    endtask
    task automatic summarize();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        summarize();
    end
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].wr) wb_xfer(1'b1, rows[i].wa, rows[i].wd, q);
            wb_xfer(1'b0, rows[i].ra, 32'h0000_0000, q);
            chk_val("reg read", rows[i].ex, q);
        end
        $display("register table done");
        wb_xfer(1'b1, `ASOM_ADDR_EXPO, 32'h0000_0002, q);
        wb_xfer(1'b1, `ASOM_ADDR_STDL, 32'h0000_0001, q);
        wb_xfer(1'b1, `ASOM_ADDR_DBNC, 32'h0000_0003, q);
        wb_xfer(1'b1, `ASOM_ADDR_TXDL, 32'h0000_0001, q);
        wb_xfer(1'b1, `ASOM_ADDR_GEOM, 32'h0008_0001, q);
        for (k = 0; k < 2; k++) begin
            wb_xfer(1'b1, `ASOM_ADDR_LINE, k ? 32'h0000_0211 : 32'h0000_0121, q);
            wb_xfer(1'b1, `ASOM_ADDR_CTRL, k ? 32'h0000_0001 : 32'h0000_0003, q);
            wait_for(frm, 1'b1, n);
            repeat (3) @(posedge clk_i);
            chk_bit("frame wait", 1'b1, frm);
            chk_bit("spare idle", k[0], spare);
            chk_bit("line idle", !k[0], line_w);
            wb_xfer(1'b0, `ASOM_ADDR_STAT, 32'h0000_0000, q);
            chk_bit("line readback", !k[0], q[5]);
            fire <= 1'b1;
            wait_for(trig, 1'b1, n);
            wait_for(expo, 1'b1, d);
            fire <= 1'b0;
            chk_len("start delay", k ? 1 : 4, d);
            repeat (2) @(posedge clk_i);
            chk_bit("spare expo", 1'b1, spare);
            chk_bit("line expo", 1'b1, line_w);
            wait_for(expo, 1'b0, d);
            chk_len("exposure", 2, d + 2);
            chk_bit("frame end", 1'b0, frm);
            chk_bit("readout", 1'b1, ro);
            wait_for(tx, 1'b1, d);
            chk_len("tx delay", 1, d);
            wait_for(ro, 1'b0, r);
            wait_for(tx, 1'b0, t);
            chk_len("readout", 2, d + r);
            chk_val("tx length", d + r, r + t);
            $display("frame %0d done", k);
        end
        wb_xfer(1'b1, `ASOM_ADDR_LINE, 32'h0000_0020, q);
        repeat (3) @(posedge clk_i);
        chk_bit("line enable", 1'b0, l1oe);
        chk_bit("line input", 1'b0, line_w);
        chk_bit("spare low", 1'b0, spare);
        wb_xfer(1'b1, `ASOM_ADDR_LINE, 32'h0000_0300, q);
        repeat (3) @(posedge clk_i);
        chk_bit("spare code 3", 1'b0, spare);
        $display("line input test done");
        wb_xfer(1'b1, `ASOM_ADDR_CTRL, 32'h0000_0000, q);
        repeat (3) @(posedge clk_i);
        chk_bit("frame disarm", 1'b0, frm);
        wb_xfer(1'b1, `ASOM_ADDR_CTRL, 32'h0000_0001, q);
        wait_for(frm, 1'b1, n);
        chk_bit("frame rearm", 1'b1, frm);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk_bit("reset frame", 1'b0, frm);
        chk_bit("reset spare", 1'b0, spare);
        wb_xfer(1'b0, `ASOM_ADDR_EXPO, 32'h0000_0000, q);
        chk_val("reset expo", 32'h0000_0064, q);
        wb_xfer(1'b0, `ASOM_ADDR_ROUT, 32'h0000_0000, q);
        chk_val("reset rout", 32'h0000_4000, q);
        $display("reset test done");
        summarize();
    end
endmodule // asom_tb_top
`default_nettype wire
